// [design/sdi_device.sv]
`timescale 1ns/1ns
`default_nettype none
`include "sdi_consts.svh"
module sdi_device (
    input  wire logic          ref_clk,
    input  wire logic          arst_n,
    sdi_link_if.device         link,
    input  wire sdi_pkg::sdi_res_e res_sel,
    output logic [11:0]        dac_code,
    output sdi_pkg::sdi_mode_e dac_mode,
    output logic               update_pulse,
    output logic               abort_pulse
);
    ////////////////////////////////////////////////////////////////////////
    // Pin sampling: frame, clock and data each pass three flip-flops
    // A level counts once stages two and three agree; a one-cycle glitch is dropped
    // Costs three cycles of delay; the serial clock must stand high and low at least two cycles each
    // Index 0 frame select, 1 serial clock, 2 data
    localparam logic [2:0] PIN_IDLE = `SDI_PIN_IDLE;
    logic [2:0]            pin_raw;
    wire  [2:0]            pin_lvl_r;
    wire  [2:0]            pin_lvl_nxt;

    assign pin_raw = {link.sdata, link.sclk, link.frame_n};

    for (genvar g = 0; g < 3; g++) begin : g_pin
        logic [2:0] sync_r;
        logic [2:0] sync_nxt;
        logic       lvl_r;
        logic       lvl_nxt;

        // First stage is read by the second stage only
        always_comb begin
            sync_nxt = {sync_r[1:0], pin_raw[g]};
            if (sync_r[1] == sync_r[2]) begin
                lvl_nxt = sync_r[2];
            end else begin
                lvl_nxt = lvl_r;
            end
        end

        // Idle levels after reset, so no false edge follows it
        always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
                sync_r <= {3{PIN_IDLE[g]}};
                lvl_r  <= PIN_IDLE[g];
            end else begin
                sync_r <= sync_nxt;
                lvl_r  <= lvl_nxt;
            end
        end

        assign pin_lvl_r[g]   = lvl_r;
        assign pin_lvl_nxt[g] = lvl_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // Shift engine
    logic               fs_fall;
    logic               fs_rise;
    logic               ck_fall;
    logic               take_bit;
    logic               apply_word;
    logic               drop_word;
    logic [15:0]        word;
    logic [15:0]        shift_r;
    logic [15:0]        shift_nxt;
    logic [4:0]         cnt_r;
    logic [4:0]         cnt_nxt;
    logic               armed_r;
    logic               armed_nxt;

    assign fs_fall    = pin_lvl_r[0] & ~pin_lvl_nxt[0];
    assign fs_rise    = ~pin_lvl_r[0] & pin_lvl_nxt[0];
    assign ck_fall    = pin_lvl_r[1] & ~pin_lvl_nxt[1];
    // Frame edges win over a clock fall in the same cycle
    // Bits are taken only while armed inside a frame
    assign take_bit   = ~fs_fall & ~fs_rise & ~pin_lvl_r[0] & armed_r & ck_fall;
    assign apply_word = take_bit & (cnt_r == `SDI_LAST_BIT);
    assign drop_word  = fs_rise & armed_r & (cnt_r != `SDI_WORD_CNT);
    assign word       = {shift_r[14:0], pin_lvl_nxt[2]};

    always_comb begin
        shift_nxt = shift_r;
        cnt_nxt   = cnt_r;
        armed_nxt = armed_r;
        if (fs_fall) begin
            armed_nxt = 1'b1;
            cnt_nxt   = 5'h00;
            shift_nxt = 16'h0000;
        end else if (fs_rise) begin
            shift_nxt = 16'h0000;
            cnt_nxt   = 5'h00;
            armed_nxt = 1'b0;
        end else if (take_bit) begin
            shift_nxt = word;
            cnt_nxt   = cnt_r + 5'h01;
            if (apply_word) begin
                // Later clock falls are ignored until the next frame fall
                armed_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            shift_r <= 16'h0000;
            cnt_r   <= 5'h00;
            armed_r <= 1'b0;
        end else begin
            shift_r <= shift_nxt;
            cnt_r   <= cnt_nxt;
            armed_r <= armed_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Applied code and mode stand until the next complete word
    logic [11:0]        code_r;
    logic [11:0]        code_nxt;
    sdi_pkg::sdi_mode_e mode_r;
    sdi_pkg::sdi_mode_e mode_nxt;

    // A cut frame never reaches here, so it leaves both untouched
    always_comb begin
        code_nxt = code_r;
        mode_nxt = mode_r;
        if (apply_word) begin
            mode_nxt = sdi_pkg::sdi_mode_e'({word[`SDI_MODE_HI_POS],
                                              word[`SDI_MODE_LO_POS]});
            // Mode change never touches the code path
            case (res_sel)
                sdi_pkg::SDI_RES_8: begin
                    code_nxt = {4'h0, word[`SDI_CODE_MSB_POS -: 8]};
                end
                sdi_pkg::SDI_RES_10: begin
                    code_nxt = {2'h0, word[`SDI_CODE_MSB_POS -: 10]};
                end
                sdi_pkg::SDI_RES_12: begin
                    code_nxt = word[`SDI_CODE_MSB_POS -: 12];
                end
                default: begin
                    code_nxt = word[`SDI_CODE_MSB_POS -: 12];
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            code_r <= `SDI_CODE_RESET;
            mode_r <= sdi_pkg::SDI_MODE_NORMAL;
        end else begin
            code_r <= code_nxt;
            mode_r <= mode_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // One-cycle event pulses
    logic               upd_r;
    logic               upd_nxt;
    logic               abt_r;
    logic               abt_nxt;

    // Abort also pulses for a frame with no clock falls at all
    always_comb begin
        upd_nxt = 1'b0;
        abt_nxt = 1'b0;
        if (apply_word) begin
            upd_nxt = 1'b1;
        end
        if (drop_word) begin
            abt_nxt = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            upd_r <= 1'b0;
            abt_r <= 1'b0;
        end else begin
            upd_r <= upd_nxt;
            abt_r <= abt_nxt;
        end
    end

    assign dac_code     = code_r;
    assign dac_mode     = mode_r;
    assign update_pulse = upd_r;
    assign abort_pulse  = abt_r;
endmodule : sdi_device
`default_nettype wire

// [design/sdi_consts.svh]
`ifndef SDI_CONSTS_SVH
`define SDI_CONSTS_SVH
// Word layout, MSB first on the wire
`define SDI_WORD_BITS      16
`define SDI_MODE_HI_POS    15
`define SDI_MODE_LO_POS    14
`define SDI_CODE_MSB_POS   13
`define SDI_CODE_RESET     12'h000
`define SDI_MODE_RESET     2'h0
// Idle pin levels after reset: data low, clock high, frame high
`define SDI_PIN_IDLE       3'h3
// Falls counted before the last bit, and the count once a word is whole
`define SDI_LAST_BIT       5'h0F
`define SDI_WORD_CNT       5'h10
// Master serial clock divider: half period in ref_clk cycles
`define SDI_SCLK_HALF      4'h4
// Least frame select high time, ns, and cycles at 100 ns per cycle
`define SDI_FS_HIGH_NS     20
`define SDI_CLK_NS         100
`define SDI_FS_HIGH_CYC    ((`SDI_FS_HIGH_NS + `SDI_CLK_NS - 1) / `SDI_CLK_NS)
`endif

// [design/sdi_pkg.sv]
package sdi_pkg;
    typedef logic [15:0] sdi_word_t;
    typedef logic [11:0] sdi_code_t;
    typedef enum logic [1:0] {
        SDI_MODE_NORMAL,
        SDI_MODE_PD_1K,
        SDI_MODE_PD_100K,
        SDI_MODE_PD_HIZ
    } sdi_mode_e;
    typedef enum logic [1:0] {
        SDI_RES_8,
        SDI_RES_10,
        SDI_RES_12
    } sdi_res_e;
endpackage : sdi_pkg

// [design/sdi_link_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface sdi_link_if;
    logic frame_n;
    logic sclk;
    logic sdata;
    modport master (output frame_n, output sclk, output sdata);
    modport device (input frame_n, input sclk, input sdata);
endinterface : sdi_link_if
`default_nettype wire

// [design/sdi_master.sv]
`timescale 1ns/1ns
`default_nettype none
`include "sdi_consts.svh"
module sdi_master (
    input  wire logic          ref_clk,
    input  wire logic          arst_n,
    sdi_link_if.master         link,
    input  wire logic          req_valid,
    input  wire logic [15:0]   req_word,
    output logic               req_ready,
    output logic               done_pulse
);
    typedef enum logic [1:0] {SDI_M_IDLE, SDI_M_LOW, SDI_M_HIGH, SDI_M_GAP} sdi_mst_e;
    sdi_mst_e    st_r, st_nxt;
    logic [15:0] sh_r, sh_nxt;
    logic [4:0]  bit_r, bit_nxt;
    logic [3:0]  div_r, div_nxt;
    logic        fs_r, fs_nxt, ck_r, ck_nxt, dt_r, dt_nxt, dn_r, dn_nxt;
    logic        ready_r, ready_nxt;
    logic        tick;

    // Half period of 4 cycles gives an 800 ns serial clock, well under the limit
    assign tick = (div_r == `SDI_SCLK_HALF - 4'h1);

    always_comb begin
        st_nxt  = st_r;
        sh_nxt  = sh_r;
        bit_nxt = bit_r;
        div_nxt = tick ? 4'h0 : div_r + 4'h1;
        fs_nxt  = fs_r;
        ck_nxt  = ck_r;
        dt_nxt  = dt_r;
        dn_nxt  = 1'b0;
        case (st_r)
            SDI_M_IDLE: begin
                div_nxt = 4'h0;
                if (req_valid) begin
                    fs_nxt  = 1'b0;
                    sh_nxt  = {req_word[14:0], 1'b0};
                    dt_nxt  = req_word[15];
                    bit_nxt = 5'h00;
                    st_nxt  = SDI_M_HIGH;
                end
            end
            SDI_M_HIGH: if (tick) begin
                ck_nxt = 1'b0;
                st_nxt = SDI_M_LOW;
            end
            SDI_M_LOW: if (tick) begin
                ck_nxt  = 1'b1;
                bit_nxt = bit_r + 5'h01;
                if (bit_r == 5'h0F) begin
                    st_nxt = SDI_M_GAP;
                end else begin
                    dt_nxt = sh_r[15];
                    sh_nxt = {sh_r[14:0], 1'b0};
                    st_nxt = SDI_M_HIGH;
                end
            end
            SDI_M_GAP: if (tick) begin
                // Frame stays high a full tick before idle, or the device filter loses it
                if (fs_r) begin
                    st_nxt = SDI_M_IDLE;
                end else begin
                    fs_nxt = 1'b1;
                    dn_nxt = 1'b1;
                end
            end
            default: st_nxt = SDI_M_IDLE;
        endcase
        ready_nxt = (st_nxt == SDI_M_IDLE) & fs_nxt;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r  <= SDI_M_IDLE;
            sh_r  <= 16'h0000;
            bit_r <= 5'h00;
            div_r <= 4'h0;
            fs_r  <= 1'b1;
            ck_r  <= 1'b1;
            dt_r  <= 1'b0;
            dn_r  <= 1'b0;
            ready_r <= 1'b1;
        end else begin
            st_r  <= st_nxt;
            sh_r  <= sh_nxt;
            bit_r <= bit_nxt;
            div_r <= div_nxt;
            fs_r  <= fs_nxt;
            ck_r  <= ck_nxt;
            dt_r  <= dt_nxt;
            dn_r  <= dn_nxt;
            ready_r <= ready_nxt;
        end
    end

    assign link.frame_n = fs_r;
    assign link.sclk    = ck_r;
    assign link.sdata   = dt_r;
    assign req_ready    = ready_r;
    assign done_pulse   = dn_r;
endmodule : sdi_master
`default_nettype wire

// [sim/sdi_properties.sv]
`timescale 1ns/1ns
`default_nettype none
module sdi_properties (
    input wire logic               ref_clk,
    input wire logic               arst_n,
    input wire logic               frame_n,
    input wire logic               sclk,
    input wire logic               sdata,
    input wire logic [11:0]        dac_code,
    input wire sdi_pkg::sdi_mode_e dac_mode,
    input wire logic               update_pulse,
    input wire logic               abort_pulse
);
    logic       sclk_r;
    logic       frame_r;
    logic [4:0] cnt_r;
    logic [4:0] cnt_nxt;
    // Falls counted on the wire itself, so device latency is judged independently
    always_comb begin
        cnt_nxt = cnt_r;
        if (frame_r && !frame_n)
            cnt_nxt = 5'h00;
        else if (!frame_n && sclk_r && !sclk)
            cnt_nxt = cnt_r + 5'h01;
    end
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_r  <= 1'b1;
            frame_r <= 1'b1;
            cnt_r   <= 5'h00;
        end else begin
            sclk_r  <= sclk;
            frame_r <= frame_n;
            cnt_r   <= cnt_nxt;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    chk_sclk_idle_high: assert property (frame_n |-> sclk)
        else $error("serial clock not idle outside frame");
    chk_code_held: assert property (!update_pulse |-> $stable(dac_code))
        else $error("code changed without update");
    chk_mode_held: assert property (!update_pulse |-> $stable(dac_mode))
        else $error("mode changed without update");
    chk_update_on_16: assert property (update_pulse |-> cnt_r == 5'h10)
        else $error("update without sixteen falls");
    chk_update_soon: assert property ($rose(cnt_r == 5'h10) |-> ##[1:8] update_pulse)
        else $error("no update after sixteenth fall");
    chk_update_single: assert property (update_pulse |=> !update_pulse)
        else $error("update pulse too long");
    chk_no_abort: assert property (!abort_pulse)
        else $error("abort on a complete frame");
    chk_frame_gap: assert property ($rose(frame_n) |=> frame_n [*3])
        else $error("frame high gap too short");
    chk_data_steady: assert property (!frame_n && !sclk |-> $stable(sdata))
        else $error("data moved while clock low");
    cover property (update_pulse && dac_mode == sdi_pkg::SDI_MODE_PD_HIZ);
    cover property (update_pulse && dac_code == 12'hFFF);
    cover property ($rose(frame_n));
endmodule : sdi_properties
`default_nettype wire

// [sim/serial_dac_input_port_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module serial_dac_input_port_tb;
    logic               ref_clk = 1'b0;
    logic               arst_n = 1'b0;
    logic               req_valid = 1'b0;
    logic [15:0]        req_word = 16'h0000;
    logic               req_ready, done_pulse, up_a, ab_a, up_b, ab_b;
    logic [11:0]        code_a, code_b;
    sdi_pkg::sdi_mode_e mode_a, mode_b;
    sdi_pkg::sdi_res_e  res_a = sdi_pkg::SDI_RES_12;
    int                 fail_count = 0, comparisons = 0, n_upd = 0, n_upd_b = 0, n_abt_b = 0;
    int                 seed;
    logic [15:0]        w;
    sdi_link_if link();
    sdi_link_if link_b();
    sdi_master u_sdi_master (.ref_clk(ref_clk), .arst_n(arst_n), .link(link.master),
        .req_valid(req_valid), .req_word(req_word), .req_ready(req_ready), .done_pulse(done_pulse));
    sdi_device u_sdi_device (.ref_clk(ref_clk), .arst_n(arst_n), .link(link.device),
        .res_sel(res_a), .dac_code(code_a), .dac_mode(mode_a), .update_pulse(up_a), .abort_pulse(ab_a));
    // Second device faces the bench so that broken frames can be sent
    sdi_device u_sdi_device_b (.ref_clk(ref_clk), .arst_n(arst_n), .link(link_b.device),
        .res_sel(sdi_pkg::SDI_RES_12), .dac_code(code_b), .dac_mode(mode_b),
        .update_pulse(up_b), .abort_pulse(ab_b));
    sdi_properties u_sdi_properties (.ref_clk(ref_clk), .arst_n(arst_n), .frame_n(link.frame_n),
        .sclk(link.sclk), .sdata(link.sdata), .dac_code(code_a), .dac_mode(mode_a),
        .update_pulse(up_a), .abort_pulse(ab_a));
    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        n_upd += up_a;
        n_upd_b += up_b;
        n_abt_b += ab_b;
    end
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] exp_code(input logic [15:0] v, input sdi_pkg::sdi_res_e r);
        case (r)
            sdi_pkg::SDI_RES_8: return {8'h00, v[13:6]};
            sdi_pkg::SDI_RES_10: return {6'h00, v[13:4]};
            default: return {4'h0, v[13:2]};
        endcase
    endfunction : exp_code
    task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    task automatic bounded(input logic done, input int n);
        if (!done && n >= 400) begin
            fail_count++;
            final_report();
        end
    endtask : bounded
    task automatic send_a(input logic [15:0] v);
        int n = 0;
        req_valid <= 1'b1;
        req_word <= v;
        while (!req_ready && n < 400) begin
            @(negedge ref_clk);
            n++;
        end
        bounded(req_ready, n);
        @(posedge ref_clk);
        req_valid <= 1'b0;
        n = 0;
        while (!done_pulse && n < 400) begin
            @(negedge ref_clk);
            n++;
        end
        bounded(done_pulse, n);
    endtask : send_a
    // Bench-made link clock: 800 ns period, MSB first, stands still between frames
    task automatic frame_b(input logic [19:0] v, input int nb);
        @(posedge ref_clk);
        link_b.frame_n <= 1'b0;
        for (int i = 0; i < nb; i++) begin
            link_b.sdata <= v[19-i];
            repeat (4) @(posedge ref_clk);
            link_b.sclk <= 1'b0;
            repeat (4) @(posedge ref_clk);
            link_b.sclk <= 1'b1;
        end
        repeat (4) @(posedge ref_clk);
        link_b.frame_n <= 1'b1;
        link_b.sdata <= ~link_b.sdata;
        repeat (10) @(negedge ref_clk);
    endtask : frame_b
    task automatic chk_b(input logic [15:0] v, input int nu, input int na);
        check("code_b", {4'h0, code_b}, {4'h0, v[13:2]});
        check("mode_b", {14'h0, mode_b}, {14'h0, v[15:14]});
        check("updates_b", n_upd_b[15:0], nu[15:0]);
        check("aborts_b", n_abt_b[15:0], na[15:0]);
    endtask : chk_b
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'hfe4d;
        link_b.frame_n = 1'b1;
        link_b.sclk = 1'b1;
        link_b.sdata = 1'b0;
        repeat (10) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(negedge ref_clk);
        check("code_a", {4'h0, code_a}, 16'h0000);
        check("mode_a", {14'h0, mode_a}, 16'h0000);
        for (int i = 0; i < 24; i++) begin
            w = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : (i == 2) ? 16'h7FFC :
                16'($random(seed));
            w[15:14] = i[1:0];
            @(posedge ref_clk);
            res_a <= sdi_pkg::sdi_res_e'(($unsigned($random(seed)) % 3));
            send_a(w);
            check("code_a", {4'h0, code_a}, exp_code(w, res_a));
            check("mode_a", {14'h0, mode_a}, {14'h0, w[15:14]});
        end
        check("updates_a", n_upd[15:0], 16'h0018);
        @(posedge ref_clk);
        frame_b({16'h4ABC, 4'hA}, 20);
        chk_b(16'h4ABC, 1, 0);
        frame_b({16'hFFFF, 4'h0}, 15);
        chk_b(16'h4ABC, 1, 1);
        frame_b(20'h00000, 0);
        chk_b(16'h4ABC, 1, 2);
        frame_b({16'hC123, 4'h0}, 16);
        chk_b(16'hC123, 2, 2);
        final_report();
    end
endmodule : serial_dac_input_port_tb
`default_nettype wire
